// >>> hw/alu_pkg.sv
// Constants, operation codes and register map of the byte arithmetic and logic unit.
// Assumes a single 25 MHz core clock and an Avalon-MM master with waitrequest.
//
// Contract
// - Register add writes dest plus source, plus carry for the carry form, sets Z C N V H in 1 cycle.
// - Register subtract writes dest minus source, minus carry for the borrow form, sets Z C N V H in 1 cycle.
// - Constant subtract, with or without borrow, writes dest and sets Z C N V H in 1 cycle.
// - Pair add-immediate adds to the 16-bit high:low pair, writes both halves, sets Z C N V S in 2 cycles.
// - Pair subtract-immediate subtracts from the 16-bit pair, writes both halves, sets Z C N V S in 2 cycles.
// - AND with source or immediate writes dest, sets Z N V, keeps carry, in 1 cycle.
// - OR with source or immediate and XOR with source write dest and set only Z N V in 1 cycle.
// - Bit set ORs the immediate mask into dest, sets Z N V in 1 cycle.
// - Bit clear ANDs dest with all-ones minus the mask, sets Z N V in 1 cycle.
// - Unsigned, signed and signed-by-unsigned multiply put the 16-bit product in R1:R0, set Z C, in 2 cycles.
// - Fractional multiplies shift the product left by one before writing R1:R0, set Z C, in 2 cycles.

package alu_pkg;

  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;

  // Byte addresses of the word-aligned registers.
  localparam logic [ADDR_W-1:0] REG_DEST = 5'h00;
  localparam logic [ADDR_W-1:0] REG_DEST_HI = 5'h04;
  localparam logic [ADDR_W-1:0] REG_SRC = 5'h08;
  localparam logic [ADDR_W-1:0] REG_OP = 5'h0c;
  localparam logic [ADDR_W-1:0] REG_FLAGS = 5'h10;
  localparam logic [ADDR_W-1:0] REG_PROD_LO = 5'h14;
  localparam logic [ADDR_W-1:0] REG_PROD_HI = 5'h18;
  localparam logic [ADDR_W-1:0] REG_STATUS = 5'h1c;

  // Flag positions in the status byte.
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;

  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam logic [7:0] BYTE_ONES = 8'hff;
  localparam logic [7:0] BYTE_MIN_NEG = 8'h80;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;

  typedef enum logic [4:0] {
    OP_ADD = 5'h00,
    OP_ADD_CARRY = 5'h01,
    OP_SUB = 5'h02,
    OP_MINUS_REG_BORROW = 5'h03,
    OP_MINUS_CONST = 5'h04,
    OP_MINUS_CONST_BORROW = 5'h05,
    OP_PAIR_ADD_IMM = 5'h06,
    OP_PAIR_MINUS_IMM = 5'h07,
    OP_AND = 5'h08,
    OP_AND_IMM = 5'h09,
    OP_OR = 5'h0a,
    OP_OR_IMM = 5'h0b,
    OP_XOR_REG = 5'h0c,
    OP_SET_BITS_IMM = 5'h0d,
    OP_CLEAR_BITS_IMM = 5'h0e,
    OP_INVERT_ALL = 5'h0f,
    OP_SIGN_FLIP = 5'h10,
    OP_INC = 5'h11,
    OP_UNSIGNED_PRODUCT = 5'h12,
    OP_SIGNED_PRODUCT = 5'h13,
    OP_SIGNED_BY_UNSIGNED = 5'h14,
    OP_FRAC_UNSIGNED = 5'h15,
    OP_FRAC_SIGNED = 5'h16,
    OP_FRAC_SIGNED_BY_UNSIGNED = 5'h17
  } alu_op_t;

  // Gray-coded: idle and the second cycle of a long operation.
  typedef enum logic {
    STAGE_IDLE = 1'b0,
    STAGE_SECOND = 1'b1
  } stage_t;

endpackage

// >>> hw/byte_arith_logic_unit.sv
// Byte arithmetic and logic unit with its operand, flag and product registers.
// Assumes an Avalon-MM master on the same clock that honours waitrequest.
//
// Chosen here: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ns

module byte_arith_logic_unit
  import alu_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [DATA_W-1:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [DATA_W-1:0] readdata,
  output logic waitrequest,
  output logic busy,
  output logic [7:0] flags
);

  // ****************************************************************
  // State record
  // ****************************************************************
  // Every register of the unit sits in this one record, so reset and the
  // clocked update cannot drift apart as fields are added.
  typedef struct packed {
    logic wait_r;
    logic busy_r;
    logic [DATA_W-1:0] rdata;
    logic [7:0] dst;
    logic [7:0] dst_hi;
    logic [7:0] src;
    logic [7:0] prod_lo;
    logic [7:0] prod_hi;
    logic [7:0] sreg;
    alu_op_t op;
    stage_t stage;
  } state_t;

  state_t st_q;
  state_t st_d;

  // ****************************************************************
  // Datapath
  // ****************************************************************
  // Results of the datapath, read by the register update in the same cycle.
  alu_op_t op_sel;
  logic [7:0] a;
  logic [7:0] b;
  logic c_in;
  logic [7:0] r8;
  logic [15:0] r16;
  logic [7:0] f;
  logic valid_op;
  logic long_op;

  always_comb begin
    logic [8:0] s9;
    logic [15:0] w16;
    logic [8:0] ea;
    logic [8:0] eb;
    logic [17:0] p18;
    logic [15:0] p16;
    logic borrow_in;
    logic sa;
    logic sb;
    s9 = 9'h000;
    w16 = WORD_ZERO;
    ea = 9'h000;
    eb = 9'h000;
    p18 = 18'h00000;
    p16 = WORD_ZERO;
    borrow_in = 1'b0;
    sa = 1'b0;
    sb = 1'b0;
    // In the second cycle the stored code drives the datapath; otherwise the code on
    // the bus does, so a single-cycle operation is worked out while it is written.
    op_sel = (st_q.stage == STAGE_SECOND) ? st_q.op : alu_op_t'(writedata[4:0]);
    a = st_q.dst;
    b = st_q.src;
    // Carry in comes from the stored flags, which software loads through the flag register.
    c_in = st_q.sreg[FLAG_C];
    r8 = a;
    r16 = {st_q.dst_hi, a};
    f = st_q.sreg;
    valid_op = 1'b1;
    long_op = 1'b0;
    // The flag byte starts as a copy of the stored one, so any flag that an
    // operation does not name keeps its old value.
    case (op_sel)
      OP_ADD, OP_ADD_CARRY: begin
        s9 = {1'b0, a} + {1'b0, b} + {8'h00, (op_sel == OP_ADD_CARRY) & c_in};
        r8 = s9[7:0];
        f[FLAG_C] = s9[8];
        // Half carry and overflow come from operand and result bits alone, so the
        // adder needs no extra width for them.
        f[FLAG_H] = (a[3] & b[3]) | (b[3] & ~r8[3]) | (~r8[3] & a[3]);
        f[FLAG_V] = (a[7] & b[7] & ~r8[7]) | (~a[7] & ~b[7] & r8[7]);
      end
      OP_SUB, OP_MINUS_REG_BORROW, OP_MINUS_CONST, OP_MINUS_CONST_BORROW: begin
        // The constant forms read the immediate from the source register.
        borrow_in = (op_sel == OP_MINUS_REG_BORROW) || (op_sel == OP_MINUS_CONST_BORROW);
        s9 = {1'b0, a} - {1'b0, b} - {8'h00, borrow_in & c_in};
        r8 = s9[7:0];
        f[FLAG_C] = s9[8];
        // A borrow out of bit 3 shows as half carry.
        f[FLAG_H] = (~a[3] & b[3]) | (b[3] & r8[3]) | (r8[3] & ~a[3]);
        f[FLAG_V] = (a[7] & ~b[7] & ~r8[7]) | (~a[7] & b[7] & r8[7]);
      end
      OP_PAIR_ADD_IMM, OP_PAIR_MINUS_IMM: begin
        long_op = 1'b1;
        // Carry and overflow look only at the top bit of the old high byte and of
        // the new word, since the immediate never reaches the high byte's sign.
        if (op_sel == OP_PAIR_ADD_IMM) begin
          w16 = {st_q.dst_hi, a} + {8'h00, b};
          f[FLAG_V] = ~st_q.dst_hi[7] & w16[15];
          f[FLAG_C] = ~w16[15] & st_q.dst_hi[7];
        end else begin
          w16 = {st_q.dst_hi, a} - {8'h00, b};
          f[FLAG_V] = st_q.dst_hi[7] & ~w16[15];
          f[FLAG_C] = w16[15] & ~st_q.dst_hi[7];
        end
        r16 = w16;
        f[FLAG_N] = w16[15];
        f[FLAG_S] = w16[15] ^ f[FLAG_V];
        f[FLAG_Z] = (w16 == WORD_ZERO);
      end
      OP_AND, OP_AND_IMM: begin
        r8 = a & b;
        f[FLAG_V] = 1'b0;
      end
      OP_OR, OP_OR_IMM, OP_XOR_REG: begin
        // Exclusive OR has no immediate form; both OR codes take the source register.
        r8 = (op_sel == OP_XOR_REG) ? (a ^ b) : (a | b);
        f[FLAG_V] = 1'b0;
      end
      OP_SET_BITS_IMM: begin
        r8 = a | b;
        f[FLAG_V] = 1'b0;
      end
      OP_CLEAR_BITS_IMM: begin
        // Subtracting from all ones inverts every bit of a byte mask.
        r8 = a & (BYTE_ONES - b);
        f[FLAG_V] = 1'b0;
      end
      OP_INVERT_ALL: begin
        r8 = BYTE_ONES - a;
        // Carry is set whatever the input, so it tells nothing about the old value.
        f[FLAG_C] = 1'b1;
        f[FLAG_V] = 1'b0;
      end
      OP_SIGN_FLIP: begin
        r8 = BYTE_ZERO - a;
        // Only a zero input negates without a borrow.
        f[FLAG_C] = (r8 != BYTE_ZERO);
        f[FLAG_V] = (r8 == BYTE_MIN_NEG);
        f[FLAG_H] = r8[3] | a[3];
      end
      OP_INC: begin
        // Carry is left alone so that a loop counter can step inside a carry chain.
        r8 = a + BYTE_ONE;
        f[FLAG_V] = (r8 == BYTE_MIN_NEG);
      end
      OP_UNSIGNED_PRODUCT, OP_SIGNED_PRODUCT, OP_SIGNED_BY_UNSIGNED,
      OP_FRAC_UNSIGNED, OP_FRAC_SIGNED, OP_FRAC_SIGNED_BY_UNSIGNED: begin
        long_op = 1'b1;
        sa = (op_sel != OP_UNSIGNED_PRODUCT) && (op_sel != OP_FRAC_UNSIGNED);
        sb = (op_sel == OP_SIGNED_PRODUCT) || (op_sel == OP_FRAC_SIGNED);
        // A ninth bit carries the sign, so one signed multiplier serves all forms.
        ea = {sa & a[7], a};
        eb = {sb & b[7], b};
        p18 = 18'($signed(ea) * $signed(eb));
        p16 = p18[15:0];
        // Carry takes bit 15 before any shift, so a fractional product still reports
        // the bit that the shift pushes out.
        f[FLAG_C] = p16[15];
        if ((op_sel == OP_FRAC_UNSIGNED) || (op_sel == OP_FRAC_SIGNED) ||
            (op_sel == OP_FRAC_SIGNED_BY_UNSIGNED)) begin
          r16 = {p16[14:0], 1'b0};
        end else begin
          r16 = p16;
        end
        f[FLAG_Z] = (r16 == WORD_ZERO);
      end
      default: begin
        // Unused codes are marked here so that the update leaves every register alone.
        valid_op = 1'b0;
      end
    endcase
    // Word and multiply forms set zero over sixteen bits above; byte forms set it here.
    if (!long_op) begin
      f[FLAG_N] = r8[7];
      f[FLAG_Z] = (r8 == BYTE_ZERO);
    end
  end

  // ****************************************************************
  // Bus slave and sequencing
  // ****************************************************************
  // Read and write must never be high together; a master that breaks this gets a write.
  logic req;
  logic commit;
  logic wr_lane;

  assign req = read | write;
  // Only byte lane 0 carries data; a write with that lane off is dropped whole.
  assign wr_lane = write & byteenable[0];
  // The access completes at the edge where waitrequest is seen low.
  assign commit = req & ~st_q.wait_r;

  // ****************************************************************
  // Register update
  // ****************************************************************
  // The slave answers after one wait state, or later when the access arrives during
  // the second cycle of a long operation; a master must wait for waitrequest to fall
  // and never count on a fixed figure.
  always_comb begin
    st_d = st_q;
    st_d.wait_r = 1'b1;
    if (st_q.stage == STAGE_SECOND) begin
      // Second cycle of a long operation: bus stays stalled meanwhile.
      // Products go to their own pair, so the operands survive a multiply.
      if ((st_q.op == OP_PAIR_ADD_IMM) || (st_q.op == OP_PAIR_MINUS_IMM)) begin
        st_d.dst = r16[7:0];
        st_d.dst_hi = r16[15:8];
      end else begin
        st_d.prod_lo = r16[7:0];
        st_d.prod_hi = r16[15:8];
      end
      st_d.sreg = f;
      st_d.stage = STAGE_IDLE;
      st_d.busy_r = 1'b0;
    end else if (commit) begin
      if (wr_lane) begin
        case (address)
          REG_DEST: st_d.dst = writedata[7:0];
          REG_DEST_HI: st_d.dst_hi = writedata[7:0];
          REG_SRC: st_d.src = writedata[7:0];
          REG_FLAGS: st_d.sreg = writedata[7:0];
          // An unknown code changes nothing, not even the stored code, so a read
          // still returns the last operation that ran.
          REG_OP: begin
            if (valid_op) begin
              st_d.op = op_sel;
              // A long operation reads its operands again in the second cycle, which
              // is safe because the bus is stalled until it is done.
              if (long_op) begin
                st_d.stage = STAGE_SECOND;
                st_d.busy_r = 1'b1;
              end else begin
                st_d.dst = r8;
                st_d.sreg = f;
              end
            end
          end
          default: begin
          end
        endcase
      end
    end else if (req) begin
      st_d.wait_r = 1'b0;
      // Read data is caught one edge before the master takes it; nothing can change
      // the register in between, since writes only land on a commit.
      st_d.rdata = READ_ZERO;
      case (address)
        REG_DEST: st_d.rdata[7:0] = st_q.dst;
        REG_DEST_HI: st_d.rdata[7:0] = st_q.dst_hi;
        REG_SRC: st_d.rdata[7:0] = st_q.src;
        REG_OP: st_d.rdata[4:0] = st_q.op;
        REG_FLAGS: st_d.rdata[7:0] = st_q.sreg;
        REG_PROD_LO: st_d.rdata[7:0] = st_q.prod_lo;
        REG_PROD_HI: st_d.rdata[7:0] = st_q.prod_hi;
        REG_STATUS: st_d.rdata[0] = st_q.busy_r;
        default: st_d.rdata = READ_ZERO;
      endcase
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      // Waitrequest resets high so that no access can complete right after release.
      st_q <= '{wait_r: 1'b1, busy_r: 1'b0, rdata: READ_ZERO, dst: BYTE_ZERO,
                dst_hi: BYTE_ZERO, src: BYTE_ZERO, prod_lo: BYTE_ZERO,
                prod_hi: BYTE_ZERO, sreg: FLAGS_RESET, op: OP_ADD, stage: STAGE_IDLE};
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Every output is a field of the state record, so each comes straight from a flip-flop.
  assign readdata = st_q.rdata;
  assign waitrequest = st_q.wait_r;
  assign busy = st_q.busy_r;
  assign flags = st_q.sreg;

endmodule // byte_arith_logic_unit

// >>> tb/alu_assertions.sv
// Checker on the unit's bus, busy and flag ports.
// Assumes alu_pkg is compiled first; bound to every instance of the unit.
`timescale 1ns/1ns
module alu_checker
  import alu_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] address,
  input wire logic write,
  input wire logic [DATA_W-1:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic waitrequest,
  input wire logic busy,
  input wire logic [7:0] flags
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic [4:0] opc;
  logic go;
  logic lng;
  logic lgc;
  assign opc = writedata[4:0];
  assign go = write && !waitrequest && byteenable[0] && address == REG_OP;
  assign lng = opc inside {OP_PAIR_ADD_IMM, OP_PAIR_MINUS_IMM}
    || (opc >= OP_UNSIGNED_PRODUCT && opc <= OP_FRAC_SIGNED_BY_UNSIGNED);
  assign lgc = opc >= OP_AND && opc <= OP_CLEAR_BITS_IMM;
  property p_long; go && lng |=> busy ##1 !busy; endproperty
  a_long: assert property (p_long)
    else $error("long operation busy not exactly one cycle");
  property p_short; go && !lng |=> !busy; endproperty
  a_short: assert property (p_short)
    else $error("single cycle operation raised busy");
  property p_rose; $rose(busy) |-> $past(go && lng); endproperty
  a_rose: assert property (p_rose)
    else $error("busy rose without a long operation");
  property p_stall; busy |-> waitrequest; endproperty
  a_stall: assert property (p_stall)
    else $error("access answered while busy");
  property p_flags; $changed(flags) |-> $past((write && !waitrequest) || busy); endproperty
  a_flags: assert property (p_flags)
    else $error("flags changed with no cause");
  property p_logic; go && lgc |=> !flags[FLAG_V] && flags[FLAG_C] == $past(flags[FLAG_C]); endproperty
  a_logic: assert property (p_logic)
    else $error("logic operation flag fault");
  property p_inv; go && opc == OP_INVERT_ALL |=> flags[FLAG_C]; endproperty
  a_inv: assert property (p_inv)
    else $error("invert left carry clear");
  property p_inc; go && opc == OP_INC |=> $stable(flags[FLAG_C]); endproperty
  a_inc: assert property (p_inc)
    else $error("increment changed carry");
  property p_sbit; go && opc <= OP_INC && !lng |=> $stable(flags[FLAG_S]); endproperty
  a_sbit: assert property (p_sbit)
    else $error("byte operation changed sign flag");
endmodule // alu_checker
bind byte_arith_logic_unit alu_checker u_chk (.sys_clk(sys_clk), .reset(reset), .address(address),
  .write(write), .writedata(writedata), .byteenable(byteenable), .waitrequest(waitrequest),
  .busy(busy), .flags(flags));

// >>> tb/bus_master_model.sv
// Avalon-MM master standing in for the decoder and register file side.
// Assumes the unit on the same clock; the bench's own timeout ends any wait.
`timescale 1ns/1ns
module bus_master_model
  import alu_pkg::*;
(
  input wire logic sys_clk,
  input wire logic waitrequest,
  input wire logic [DATA_W-1:0] readdata,
  output logic [ADDR_W-1:0] address,
  output logic read,
  output logic write,
  output logic [DATA_W-1:0] writedata,
  output logic [3:0] byteenable
);
  initial begin
    address = 5'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0000_0000;
    byteenable = 4'h0;
  end
  // Released address and writedata lines show the inverse of the last value, so a stale sample cannot pass.
  task automatic xfer(input logic w, input logic [4:0] a, input logic [31:0] d,
                      input logic [3:0] be, output logic [31:0] q);
    @(posedge sys_clk);
    address <= a;
    writedata <= d;
    byteenable <= be;
    read <= !w;
    write <= w;
    do @(posedge sys_clk); while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    address <= ~a;
    writedata <= ~d;
  endtask
endmodule // bus_master_model

// >>> tb/tb.sv
// Self-checking bench: runs every operation through the register bus.
// Assumes the unit, its package, the checker and the bus master model.
`timescale 1ns/1ns
module tb;
  import alu_pkg::*;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [ADDR_W-1:0] address;
  logic read;
  logic write;
  logic [DATA_W-1:0] writedata;
  logic [3:0] byteenable;
  logic [DATA_W-1:0] readdata;
  logic waitrequest;
  logic busy;
  logic [7:0] flags;
  logic [31:0] q;
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;
  always #20 sys_clk = ~sys_clk;
  bus_master_model u_bus (.sys_clk(sys_clk), .waitrequest(waitrequest), .readdata(readdata),
    .address(address), .read(read), .write(write), .writedata(writedata), .byteenable(byteenable));
  byte_arith_logic_unit u_dut (.sys_clk(sys_clk), .reset(reset), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .busy(busy), .flags(flags));
  task automatic end_sim;
    if (fail_count == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // The whole run needs about 740 cycles; the ceiling leaves ample margin.
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      fail_count++;
      end_sim();
    end
  end
  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(logic [4:0] a, logic [7:0] d);
    logic [31:0] r;
    u_bus.xfer(1'b1, a, {24'h000000, d}, 4'hf, r);
  endtask
  task automatic op_chk(alu_op_t op, logic [15:0] d, logic [7:0] s, logic [7:0] fin,
                        logic [4:0] ra, logic [15:0] rexp, logic [7:0] fexp);
    logic [31:0] lo;
    logic [31:0] hi;
    logic [31:0] f;
    wr(REG_DEST, d[7:0]);
    wr(REG_DEST_HI, d[15:8]);
    wr(REG_SRC, s);
    wr(REG_FLAGS, fin);
    wr(REG_OP, {3'h0, op});
    u_bus.xfer(1'b0, ra, 32'h0, 4'hf, lo);
    u_bus.xfer(1'b0, ra + 5'h04, 32'h0, 4'hf, hi);
    u_bus.xfer(1'b0, REG_FLAGS, 32'h0, 4'hf, f);
    check("result", {hi[7:0], lo[7:0]}, rexp);
    check("flags", {8'h00, f[7:0]}, {8'h00, fexp});
    u_bus.xfer(1'b0, REG_OP, 32'h0, 4'hf, lo);
    @(negedge sys_clk);
    check("last op", lo[15:0], {11'h000, op});
    check("flags port", {8'h00, flags}, {8'h00, fexp});
    check("busy", {15'h0000, busy}, 16'h0000);
  endtask
  task automatic t_arith;
    op_chk(OP_ADD_CARRY, 16'h007f, 8'h00, 8'h01, REG_DEST, 16'h0080, 8'h2c);
    op_chk(OP_ADD, 16'h11ff, 8'h01, 8'h00, REG_DEST, 16'h1100, 8'h23);
    op_chk(OP_SUB, 16'h0010, 8'h01, 8'h00, REG_DEST, 16'h000f, 8'h20);
    op_chk(OP_MINUS_REG_BORROW, 16'h0000, 8'h00, 8'h01, REG_DEST, 16'h00ff, 8'h25);
    op_chk(OP_MINUS_CONST, 16'h0080, 8'h01, 8'h00, REG_DEST, 16'h007f, 8'h28);
    op_chk(OP_MINUS_CONST_BORROW, 16'h0005, 8'h04, 8'h01, REG_DEST, 16'h0000, 8'h02);
  endtask
  task automatic t_pair;
    op_chk(OP_PAIR_ADD_IMM, 16'hffff, 8'h01, 8'h20, REG_DEST, 16'h0000, 8'h23);
    op_chk(OP_PAIR_MINUS_IMM, 16'h8000, 8'h01, 8'h00, REG_DEST, 16'h7fff, 8'h18);
  endtask
  // Carry and overflow start set, so a kept carry and a cleared overflow both show.
  task automatic t_logic;
    op_chk(OP_AND, 16'h00f0, 8'h0f, 8'h09, REG_DEST, 16'h0000, 8'h03);
    op_chk(OP_AND_IMM, 16'h00f3, 8'h81, 8'h09, REG_DEST, 16'h0081, 8'h05);
    op_chk(OP_OR, 16'h0000, 8'h00, 8'h09, REG_DEST, 16'h0000, 8'h03);
    op_chk(OP_OR_IMM, 16'h0080, 8'h01, 8'h09, REG_DEST, 16'h0081, 8'h05);
    op_chk(OP_XOR_REG, 16'h00ff, 8'h7f, 8'h09, REG_DEST, 16'h0080, 8'h05);
    op_chk(OP_SET_BITS_IMM, 16'h0001, 8'h80, 8'h09, REG_DEST, 16'h0081, 8'h05);
    op_chk(OP_CLEAR_BITS_IMM, 16'h00ff, 8'hff, 8'h09, REG_DEST, 16'h0000, 8'h03);
  endtask
  task automatic t_unary;
    op_chk(OP_INVERT_ALL, 16'h0000, 8'h00, 8'h00, REG_DEST, 16'h00ff, 8'h05);
    op_chk(OP_SIGN_FLIP, 16'h0080, 8'h00, 8'h00, REG_DEST, 16'h0080, 8'h0d);
    op_chk(OP_SIGN_FLIP, 16'h0001, 8'h00, 8'h00, REG_DEST, 16'h00ff, 8'h25);
    op_chk(OP_INC, 16'h007f, 8'h00, 8'h01, REG_DEST, 16'h0080, 8'h0d);
    op_chk(OP_INC, 16'h00ff, 8'h00, 8'h00, REG_DEST, 16'h0000, 8'h02);
  endtask
  task automatic t_mul;
    op_chk(OP_UNSIGNED_PRODUCT, 16'h00ff, 8'hff, 8'h00, REG_PROD_LO, 16'hfe01, 8'h01);
    op_chk(OP_SIGNED_PRODUCT, 16'h00ff, 8'h02, 8'h00, REG_PROD_LO, 16'hfffe, 8'h01);
    op_chk(OP_SIGNED_BY_UNSIGNED, 16'h00ff, 8'hff, 8'h00, REG_PROD_LO, 16'hff01, 8'h01);
    op_chk(OP_FRAC_UNSIGNED, 16'h0080, 8'h80, 8'h00, REG_PROD_LO, 16'h8000, 8'h00);
    op_chk(OP_FRAC_SIGNED, 16'h0040, 8'h40, 8'h00, REG_PROD_LO, 16'h2000, 8'h00);
    op_chk(OP_FRAC_SIGNED_BY_UNSIGNED, 16'h0000, 8'h55, 8'h00, REG_PROD_LO, 16'h0000, 8'h02);
  endtask
  task automatic t_bus;
    u_bus.xfer(1'b0, REG_FLAGS, 32'h0, 4'hf, q);
    check("reset flags", q[15:0], 16'h0000);
    wr(REG_DEST, 8'h33);
    u_bus.xfer(1'b1, REG_DEST, 32'h44, 4'h0, q);
    wr(REG_OP, 8'h18);
    u_bus.xfer(1'b0, REG_DEST, 32'h0, 4'hf, q);
    check("ignored writes", q[15:0], 16'h0033);
    u_bus.xfer(1'b0, REG_OP, 32'h0, 4'hf, q);
    check("op after bad code", q[15:0], 16'h0000);
    u_bus.xfer(1'b0, REG_STATUS, 32'h0, 4'hf, q);
    check("status", q[15:0], 16'h0000);
    wr(REG_FLAGS, 8'hc0);
    u_bus.xfer(1'b0, REG_FLAGS, 32'h0, 4'hf, q);
    check("spare flag bits", q[15:0], 16'h00c0);
    u_bus.xfer(1'b0, 5'h01, 32'h0, 4'hf, q);
    check("unmapped read", q[15:0], 16'h0000);
  endtask
  initial begin
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    t_bus();
    t_arith();
    t_pair();
    t_logic();
    t_unary();
    t_mul();
    end_sim();
  end
endmodule // tb
